// [logic/sysctl_gpio_map.vh]
`ifndef SYSCTL_GPIO_MAP_VH
`define SYSCTL_GPIO_MAP_VH

// Register pointer values
`define SYSU_ADDR 8'h06
`define GPIO_CTL_ADDR 8'h07
`define GPIO_IN_ADDR 8'h08

// Upper system-control byte fields
`define SYSU_BUCK_CONVERTER_ENABLE_BIT 0
`define SYSU_SOFT_RESET_REQUEST_BIT 1
`define SYSU_AUTO_BIT 2
`define SYSU_RSVD_LSB 3
`define SYSU_RESET 8'hf4

// GPIO control byte fields
`define GPIO_OUT_LSB 0
`define GPIO_IBE_LSB 4
`define GPIO_CTL_RESET 8'h0f
`define GPIO_IN_RESET 8'h00

// Default 7-bit bus address of the slave port
`define SLAVE_ADDR_DEFAULT 7'h2a

`endif

// [logic/bus_line_detect.v]
`default_nettype none

module bus_line_detect (
   input wire clk_in,
   input wire rst_b_in,
   input wire scl_in,
   input wire sda_in,
   output wire scl_out,
   output wire sda_out,
   output wire scl_rise_out,
   output wire scl_fall_out,
   output wire start_out,
   output wire stop_out
);

   reg [1:0] scl_meta_q;
   reg [1:0] sda_meta_q;
   reg scl_prev_q;
   reg sda_prev_q;

   // First stage feeds only the second; edges are judged one stage later
   always @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         scl_meta_q <= 2'h3;
         sda_meta_q <= 2'h3;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end
      else
      begin
         scl_meta_q <= {scl_meta_q[0], scl_in};
         sda_meta_q <= {sda_meta_q[0], sda_in};
         scl_prev_q <= scl_meta_q[1];
         sda_prev_q <= sda_meta_q[1];
      end
   end

   // Bus conditions: data moves while clock stays high
   assign scl_out = scl_meta_q[1];
   assign sda_out = sda_meta_q[1];
   assign scl_rise_out = scl_meta_q[1] & ~scl_prev_q;
   assign scl_fall_out = ~scl_meta_q[1] & scl_prev_q;
   assign start_out = scl_meta_q[1] & scl_prev_q & sda_prev_q & ~sda_meta_q[1];
   assign stop_out = scl_meta_q[1] & scl_prev_q & ~sda_prev_q & sda_meta_q[1];

endmodule // bus_line_detect

`default_nettype wire

// [logic/gpio_input_latch.v]
`default_nettype none

module gpio_input_latch (
   input wire clk_in,
   input wire rst_b_in,
   input wire [3:0] pin_in,
   input wire [3:0] buffer_enable_in,
   output wire [3:0] latch_out
);

   genvar i;

   // One synchroniser and gated latch per pin
   generate
      for (i = 0; i < 4; i = i + 1)
      begin : g_pin
         reg meta_q;
         reg sync_q;
         reg latch_q;
         always @(posedge clk_in)
         begin
            if (!rst_b_in)
            begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
               latch_q <= 1'b0;
            end
            else
            begin
               meta_q <= pin_in[i];
               sync_q <= meta_q;
               // Buffer off reads zero, so stale levels never linger
               latch_q <= buffer_enable_in[i] & sync_q;
            end
         end
         assign latch_out[i] = latch_q;
      end
   endgenerate

endmodule // gpio_input_latch

`default_nettype wire

// [logic/sysctl_gpio_regs.v]
// How it works
// - Upper control bits 7..4 reset to one, bit 3 to zero; host writes zeros.
// - Upper control bit 0 switches the buck converter; resets to zero.
// - Writing soft reset bit restores all defaults, applied at the bus stop condition.
// - Soft reset bit clears itself during the reset it causes.
// - Bit 2 set makes the pointer step after every data byte; clear holds it.
// - Output control one leaves the pin floating; zero pulls it low.
// - Pins 1 and 2 pull low on control zero or power guard request.
// - Input buffer enables sit in bits 7..4 of the control byte, reset zero.
// - Input byte bits 3..0 return pin levels 1..4, valid with buffer enabled.
// - Control byte holds output controls in bits 3..0, resetting to one.
// - Overtemperature shutdown clears the buck enable bit automatically.
// - Thermistor guard holds pins 1 and 2 low while the high limit persists.
`default_nettype none
`include "sysctl_gpio_map.vh"

module sysctl_gpio_regs #(
   parameter [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEFAULT
) (
   input wire clk_in,
   input wire rst_b_in,
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_out,
   input wire [3:0] pin_in,
   output reg [3:0] pin_out,
   output reg [3:0] pin_oe_out,
   input wire overtemp_shutdown_enable_in,
   input wire overtemp_trip_in,
   input wire thermistor_power_guard_enable_in,
   input wire thermistor_high_limit_flag_in,
   output reg buck_converter_enable_out,
   output reg soft_reset_out
);

   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_ADDR = 4'h1;
   localparam [3:0] ST_ACK_ADDR = 4'h2;
   localparam [3:0] ST_PTR = 4'h3;
   localparam [3:0] ST_ACK_PTR = 4'h4;
   localparam [3:0] ST_WDATA = 4'h5;
   localparam [3:0] ST_ACK_W = 4'h6;
   localparam [3:0] ST_RDATA = 4'h7;
   localparam [3:0] ST_RACK = 4'h8;

   wire sda_s;
   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;
   wire soft_rst;
   wire [3:0] latch_w;
   wire [3:0] guard_low;
   wire [7:0] sysu_default;
   wire [7:0] gpio_ctl_default;

   reg [3:0] state_q;
   reg [3:0] bit_cnt_q;
   reg [7:0] shift_q;
   reg [7:0] tx_q;
   reg rw_q;
   reg nack_q;
   reg ack_oe_q;
   reg [7:0] ptr_q;
   reg wr_en_q;
   reg [7:0] wr_addr_q;
   reg [7:0] wr_data_q;

   reg buck_converter_enable_q;
   reg soft_reset_request_q;
   reg auto_increment_q;
   reg [4:0] sysu_reserved_q;
   reg [3:0] pin_output_control_q;
   reg [3:0] pin_input_buffer_enable_q;
   reg [7:0] rd_data;

   bus_line_detect u_line (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_out(),
      .sda_out(sda_s),
      .scl_rise_out(scl_rise),
      .scl_fall_out(scl_fall),
      .start_out(start_det),
      .stop_out(stop_det)
   );

   gpio_input_latch u_latch (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .pin_in(pin_in),
      .buffer_enable_in(pin_input_buffer_enable_q),
      .latch_out(latch_w)
   );

   // Pending soft reset fires only when the transfer ends with a stop
   assign soft_rst = stop_det & soft_reset_request_q;

   // Power-up images; fields are cut from them so reset and soft reset agree
   assign sysu_default = `SYSU_RESET;
   assign gpio_ctl_default = `GPIO_CTL_RESET;

   // Read data as seen at the current pointer
   always @*
   begin
      case (ptr_q)
         `SYSU_ADDR:
            rd_data = {sysu_reserved_q, auto_increment_q, soft_reset_request_q, buck_converter_enable_q};
         `GPIO_CTL_ADDR:
            rd_data = {pin_input_buffer_enable_q, pin_output_control_q};
         `GPIO_IN_ADDR:
            rd_data = {4'h0, latch_w};
         default:
            rd_data = 8'h00;
      endcase
   end

   // Slave port state machine; sda is sampled on rise, driven after fall
   always @(posedge clk_in)
   begin
      if (!rst_b_in || soft_rst)
      begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         ack_oe_q <= 1'b0;
         ptr_q <= 8'h00;
         wr_en_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
      end
      else
      begin
         wr_en_q <= 1'b0;
         if (stop_det)
         begin
            state_q <= ST_IDLE;
            ack_oe_q <= 1'b0;
         end
         else if (start_det)
         begin
            // A repeated start keeps the pointer for the following read
            state_q <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            ack_oe_q <= 1'b0;
         end
         else if (scl_rise)
         begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (state_q == ST_RACK)
               nack_q <= sda_s;
         end
         else if (scl_fall)
         begin
            case (state_q)
               ST_ADDR:
               begin
                  if (bit_cnt_q == 4'h8)
                  begin
                     if (shift_q[7:1] == SLAVE_ADDR)
                     begin
                        rw_q <= shift_q[0];
                        ack_oe_q <= 1'b1;
                        state_q <= ST_ACK_ADDR;
                     end
                     else
                        state_q <= ST_IDLE;
                  end
               end
               ST_ACK_ADDR:
               begin
                  bit_cnt_q <= 4'h0;
                  if (rw_q)
                  begin
                     tx_q <= rd_data;
                     ack_oe_q <= ~rd_data[7];
                     state_q <= ST_RDATA;
                  end
                  else
                  begin
                     ack_oe_q <= 1'b0;
                     state_q <= ST_PTR;
                  end
               end
               ST_PTR:
               begin
                  if (bit_cnt_q == 4'h8)
                  begin
                     ptr_q <= shift_q;
                     ack_oe_q <= 1'b1;
                     state_q <= ST_ACK_PTR;
                  end
               end
               ST_WDATA:
               begin
                  if (bit_cnt_q == 4'h8)
                  begin
                     wr_en_q <= 1'b1;
                     wr_addr_q <= ptr_q;
                     wr_data_q <= shift_q;
                     ack_oe_q <= 1'b1;
                     state_q <= ST_ACK_W;
                     if (auto_increment_q)
                        ptr_q <= ptr_q + 8'h01;
                  end
               end
               ST_ACK_PTR, ST_ACK_W:
               begin
                  bit_cnt_q <= 4'h0;
                  ack_oe_q <= 1'b0;
                  state_q <= ST_WDATA;
               end
               ST_RDATA:
               begin
                  if (bit_cnt_q == 4'h8)
                  begin
                     ack_oe_q <= 1'b0;
                     state_q <= ST_RACK;
                     if (auto_increment_q)
                        ptr_q <= ptr_q + 8'h01;
                  end
                  else
                  begin
                     tx_q <= {tx_q[6:0], 1'b0};
                     ack_oe_q <= ~tx_q[6];
                  end
               end
               ST_RACK:
               begin
                  bit_cnt_q <= 4'h0;
                  if (nack_q)
                     state_q <= ST_IDLE;
                  else
                  begin
                     tx_q <= rd_data;
                     ack_oe_q <= ~rd_data[7];
                     state_q <= ST_RDATA;
                  end
               end
               default:
                  state_q <= state_q;
            endcase
         end
      end
   end

   // Register file; soft reset returns every field to its default
   always @(posedge clk_in)
   begin
      if (!rst_b_in || soft_rst)
      begin
         buck_converter_enable_q <= sysu_default[`SYSU_BUCK_CONVERTER_ENABLE_BIT];
         soft_reset_request_q <= sysu_default[`SYSU_SOFT_RESET_REQUEST_BIT];
         auto_increment_q <= sysu_default[`SYSU_AUTO_BIT];
         sysu_reserved_q <= sysu_default[`SYSU_RSVD_LSB +: 5];
         pin_output_control_q <= gpio_ctl_default[`GPIO_OUT_LSB +: 4];
         pin_input_buffer_enable_q <= gpio_ctl_default[`GPIO_IBE_LSB +: 4];
      end
      else
      begin
         if (wr_en_q && wr_addr_q == `SYSU_ADDR)
         begin
            buck_converter_enable_q <= wr_data_q[`SYSU_BUCK_CONVERTER_ENABLE_BIT];
            soft_reset_request_q <= wr_data_q[`SYSU_SOFT_RESET_REQUEST_BIT];
            auto_increment_q <= wr_data_q[`SYSU_AUTO_BIT];
            sysu_reserved_q <= wr_data_q[`SYSU_RSVD_LSB +: 5];
         end
         if (wr_en_q && wr_addr_q == `GPIO_CTL_ADDR)
         begin
            pin_output_control_q <= wr_data_q[`GPIO_OUT_LSB +: 4];
            pin_input_buffer_enable_q <= wr_data_q[`GPIO_IBE_LSB +: 4];
         end
         // Protection wins over a host write in the same cycle
         if (overtemp_shutdown_enable_in && overtemp_trip_in)
            buck_converter_enable_q <= 1'b0;
      end
   end

   // Power guard only reaches the two high-voltage pins
   assign guard_low = {2'h0, {2{thermistor_power_guard_enable_in & thermistor_high_limit_flag_in}}};

   // Registered pin and bus drivers; open drain means data is always low
   always @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         pin_out <= 4'h0;
         pin_oe_out <= 4'h0;
         sda_out <= 1'b0;
         sda_oe_out <= 1'b0;
         buck_converter_enable_out <= 1'b0;
         soft_reset_out <= 1'b0;
      end
      else
      begin
         pin_out <= 4'h0;
         pin_oe_out <= ~pin_output_control_q | guard_low;
         sda_out <= 1'b0;
         sda_oe_out <= ack_oe_q & ~soft_rst;
         buck_converter_enable_out <= buck_converter_enable_q & ~soft_rst;
         soft_reset_out <= soft_rst;
      end
   end

endmodule // sysctl_gpio_regs

`default_nettype wire

// [testbench/regs_checker.sv]
`default_nettype none
module regs_checker (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe_out,
   input wire logic overtemp_shutdown_enable_in,
   input wire logic overtemp_trip_in,
   input wire logic thermistor_power_guard_enable_in,
   input wire logic thermistor_high_limit_flag_in,
   input wire logic buck_converter_enable_out,
   input wire logic soft_reset_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // Guard request held long enough to cover the pin register stage
   sequence s_guard;
      (thermistor_power_guard_enable_in && thermistor_high_limit_flag_in) [*4];
   endsequence
   // Bus clock high well before and data high now: a stop has just passed
   sequence s_stop;
      $past(scl_in, 8) && scl_in && sda_in;
   endsequence
   property p_od;
      pin_out == 4'h0 && !sda_out;
   endproperty
   a_od: assert property (p_od) else $error("open drain output driven high");
   property p_guard;
      s_guard |-> pin_oe_out[1:0] == 2'b11;
   endproperty
   a_guard: assert property (p_guard) else $error("guard did not pull pins low");
   property p_otp;
      (overtemp_shutdown_enable_in && overtemp_trip_in) [*2] |-> ##2 !buck_converter_enable_out;
   endproperty
   a_otp: assert property (p_otp) else $error("thermal trip left converter on");
   property p_sr_stop;
      soft_reset_out |-> s_stop;
   endproperty
   a_sr_stop: assert property (p_sr_stop) else $error("soft reset without stop");
   property p_sr_pulse;
      soft_reset_out |=> !soft_reset_out;
   endproperty
   a_sr_pulse: assert property (p_sr_pulse) else $error("soft reset not self clearing");
   property p_sr_buck;
      soft_reset_out |-> !buck_converter_enable_out;
   endproperty
   a_sr_buck: assert property (p_sr_buck) else $error("converter on after soft reset");
   property p_sr_pins;
      soft_reset_out |=> pin_oe_out[3:2] == 2'b00;
   endproperty
   a_sr_pins: assert property (p_sr_pins) else $error("pins driven after soft reset");
   property p_rst;
      $rose(rst_b_in) |-> !buck_converter_enable_out && !soft_reset_out;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs active out of reset");
endmodule // regs_checker

bind sysctl_gpio_regs regs_checker chk_i (
   .clk_in(clk_in),
   .rst_b_in(rst_b_in),
   .scl_in(scl_in),
   .sda_in(sda_in),
   .sda_out(sda_out),
   .pin_out(pin_out),
   .pin_oe_out(pin_oe_out),
   .overtemp_shutdown_enable_in(overtemp_shutdown_enable_in),
   .overtemp_trip_in(overtemp_trip_in),
   .thermistor_power_guard_enable_in(thermistor_power_guard_enable_in),
   .thermistor_high_limit_flag_in(thermistor_high_limit_flag_in),
   .buck_converter_enable_out(buck_converter_enable_out),
   .soft_reset_out(soft_reset_out)
);
`default_nettype wire

// [testbench/host_model.sv]
`default_nettype none
`include "sysctl_gpio_map.vh"
module host_model (
   input wire logic clk_in,
   input wire logic line_in,
   output logic scl_out,
   output logic sda_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // Bus idles released
   initial
   begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // Every change lands just after a clock edge
   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // Data raised first so the same task serves a repeated start
   task automatic start;
      sda_out = 1'b1;
      wt(8);
      scl_out = 1'b1;
      wt(8);
      sda_out = 1'b0;
      wt(8);
      scl_out = 1'b0;
      wt(4);
   endtask
   task automatic stop;
      sda_out = 1'b0;
      wt(8);
      scl_out = 1'b1;
      wt(8);
      sda_out = 1'b1;
      wt(8);
   endtask
   // Eight bits and the acknowledge; the line is sampled mid high phase, past the sync delay
   task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
      logic [8:0] s;
      logic [8:0] r;
      s = {d, m};
      for (int i = 8; i >= 0; i--)
      begin
         sda_out = s[i];
         wt(8);
         scl_out = 1'b1;
         wt(8);
         r[i] = line_in;
         wt(8);
         scl_out = 1'b0;
         wt(4);
      end
      q = r[8:1];
      a = r[0];
   endtask
   // Second byte, if any, is the inverse of d, not of the masked first byte
   task automatic wr(input logic [7:0] p, d, input int n, output logic nak);
      logic [7:0] t;
      logic [2:0] a;
      start;
      xfer({`SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1, t, a[0]);
      xfer(p, 1'b1, t, a[1]);
      xfer(p == `SYSU_ADDR ? d & 8'h07 : p == `GPIO_IN_ADDR ? d & 8'h0f : d, 1'b1, t, a[2]);
      if (n > 1)
         xfer(~d, 1'b1, t, a[2]);
      stop;
      nak = |a;
   endtask
   // Whole burst in one transaction, so no flag is lost between bytes
   task automatic rd(input logic [7:0] p, input int n, output logic [7:0] q [3]);
      logic [7:0] t;
      logic a;
      start;
      xfer({`SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1, t, a);
      xfer(p, 1'b1, t, a);
      start;
      xfer({`SLAVE_ADDR_DEFAULT, 1'b1}, 1'b1, t, a);
      for (int i = 0; i < n; i++)
         xfer(8'hff, i == n - 1, q[i], a);
      stop;
   endtask
endmodule // host_model
`default_nettype wire

// [testbench/testbench.sv]
`default_nettype none
`include "sysctl_gpio_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {
      logic [7:0] p, w, r;
      logic [3:0] lv, oe;
      logic bk;
   } row_t;
   logic clk = 1'b0;
   logic rst_b, ot_en, ot, g_en, g_fl, scl, sda_h, sda_oe, bk, sr, nak;
   logic [3:0] lv, pin_in, pin_oe;
   logic [7:0] q [3];
   wire sda;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int sr_n = 0;
   // Pointer, write value, read-back, pin levels, pulled pins, converter
   row_t rows [7] = '{
      '{8'h07, 8'hff, 8'hff, 4'h5, 4'h0, 1'b0},
      '{8'h08, 8'h0f, 8'h05, 4'h5, 4'h0, 1'b0},
      '{8'h07, 8'ha3, 8'ha3, 4'h5, 4'hc, 1'b0},
      '{8'h08, 8'h00, 8'h02, 4'hf, 4'hc, 1'b0},
      '{8'h06, 8'h05, 8'h05, 4'hf, 4'hc, 1'b1},
      '{8'h09, 8'h55, 8'h00, 4'hf, 4'hc, 1'b1},
      '{8'h06, 8'h04, 8'h04, 4'hf, 4'hc, 1'b0}};
   always #2 clk = ~clk;
   // Open-drain wires: pulled high unless someone pulls low
   assign sda = sda_h & ~sda_oe;
   assign pin_in = lv & ~pin_oe;
   sysctl_gpio_regs uut (
      .clk_in(clk),
      .rst_b_in(rst_b),
      .scl_in(scl),
      .sda_in(sda),
      .sda_out(),
      .sda_oe_out(sda_oe),
      .pin_in(pin_in),
      .pin_out(),
      .pin_oe_out(pin_oe),
      .overtemp_shutdown_enable_in(ot_en),
      .overtemp_trip_in(ot),
      .thermistor_power_guard_enable_in(g_en),
      .thermistor_high_limit_flag_in(g_fl),
      .buck_converter_enable_out(bk),
      .soft_reset_out(sr)
   );
   host_model host (
      .clk_in(clk),
      .line_in(sda),
      .scl_out(scl),
      .sda_out(sda_h)
   );
   task automatic chk(input logic [7:0] g, e);
      n_tests++;
      if (g !== e)
      begin
         bad_count++;
         $display("FAIL %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Ceiling is about two and a half times the expected run
   always @(posedge clk)
   begin
      cyc++;
      if (sr)
         sr_n++;
      if (cyc == 60000)
      begin
         bad_count++;
         end_of_test;
      end
   end
   initial
   begin
      {rst_b, ot_en, ot, g_en, g_fl} = 5'h00;
      lv = 4'hf;
      repeat (20) @(posedge clk);
      #1 rst_b = 1'b1;
      host.wt(4);
      host.rd(`SYSU_ADDR, 3, q);
      chk(q[0], 8'hf4);
      chk(q[1], 8'h0f);
      chk(q[2], 8'h00);
      foreach (rows[i])
      begin
         lv = rows[i].lv;
         host.wr(rows[i].p, rows[i].w, 1, nak);
         chk({7'h00, nak}, 8'h00);
         host.rd(rows[i].p, 1, q);
         chk(q[0], rows[i].r);
         chk({4'h0, pin_oe}, {4'h0, rows[i].oe});
         chk({7'h00, bk}, {7'h00, rows[i].bk});
      end
      // Fixed pointer: both bytes of a burst hit one register
      host.wr(`SYSU_ADDR, 8'h00, 1, nak);
      host.wr(`GPIO_CTL_ADDR, 8'h5a, 2, nak);
      host.rd(`GPIO_CTL_ADDR, 2, q);
      chk(q[0], 8'ha5);
      chk(q[1], 8'ha5);
      // Guard overrides released outputs on pins 1 and 2 only
      host.wr(`GPIO_CTL_ADDR, 8'h0f, 1, nak);
      {g_en, g_fl} = 2'b11;
      host.wt(4);
      chk({4'h0, pin_oe}, 8'h03);
      g_fl = 1'b0;
      host.wt(4);
      chk({4'h0, pin_oe}, 8'h00);
      g_en = 1'b0;
      // A trip only counts while shutdown is enabled
      host.wr(`SYSU_ADDR, 8'h01, 1, nak);
      {ot_en, ot} = 2'b01;
      host.wt(4);
      chk({7'h00, bk}, 8'h01);
      ot_en = 1'b1;
      host.wt(4);
      {ot_en, ot} = 2'b00;
      chk({7'h00, bk}, 8'h00);
      host.rd(`SYSU_ADDR, 1, q);
      chk(q[0], 8'h00);
      // Soft reset restores increment mode, so the burst walks on
      host.wr(`GPIO_CTL_ADDR, 8'h00, 1, nak);
      host.wr(`SYSU_ADDR, 8'h02, 1, nak);
      host.rd(`SYSU_ADDR, 2, q);
      chk(q[0], 8'hf4);
      chk(q[1], 8'h0f);
      chk({4'h0, pin_oe}, 8'h00);
      chk(sr_n[7:0], 8'h01);
      end_of_test;
   end
endmodule // testbench
`default_nettype wire
